// ===== logic/vsp_byte_if.sv
// Purpose: carries one received byte and its frame-start flag
// Assumes: a word moves when valid and ready are both high
// Notes:   bit 8 marks the first byte after select fell
`timescale 1ns/1ps
`default_nettype none
interface vsp_byte_if #(parameter int unsigned W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : vsp_byte_if
`default_nettype wire

// ===== logic/vsp_cmd_top.sv
// Purpose: serial command interpreter for symbol, port, duty and digits
// Assumes: display_on and char_code_in come from core_clk logic
// Notes:   one scan slot per core clock, 1024 slots per grid
`timescale 1ns/1ps
`default_nettype none
module vsp_cmd_top
  import vsp_pkg::*;
#(
  parameter int unsigned DIGITS = SYM_DIGITS,
  parameter int unsigned SLOT_W = DUTY_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              cs_n_pin,
  input  wire logic              shift_clock_n,
  input  wire logic              serial_data_in,
  input  wire logic              display_on,
  input  wire logic [7:0]        char_code_in,
  output logic [3:0]             port_level_bit,
  output logic [DIGITS-1:0]      grid_output,
  output logic [SYM_DW-1:0]      symbol_out,
  output logic                   pattern_ram_sel,
  output logic [3:0]             pattern_ram_addr,
  output logic [7:0]             rom_addr,
  output logic [DUTY_W-1:0]      duty_value,
  output logic [3:0]             digit_count,
  output logic                   overrun
);
  vsp_byte_if #(.W(FRAME_W)) rx_if ();
  vsp_byte_if #(.W(FRAME_W)) dec_if ();

  vsp_state_e        state_reg;
  logic [SYM_AW-1:0] sym_addr_reg;
  logic [SYM_DW-1:0] sym_ram_reg [DIGITS];
  logic [1:0]        duty_lo_reg;
  logic              busy_reg;
  logic              overrun_pulse;
  logic              take;
  logic              first;
  logic [7:0]        byte_in;
  logic [2:0]        sel;
  logic [SLOT_W-1:0] slot_reg;
  logic [SYM_AW-1:0] grid_reg;
  logic [SYM_AW-1:0] last_grid;
  logic              lit;

  function automatic logic [DUTY_W-1:0] clamp_duty(input logic [DUTY_W-1:0] v);
    clamp_duty = (v > DUTY_MAX) ? DUTY_MAX : v;
  endfunction : clamp_duty

  function automatic logic [SYM_AW-1:0] last_of(input logic [3:0] k);
    last_of = (k == 4'h0) ? FULL_LAST : DIGIT_OFS + SYM_AW'(k);
  endfunction : last_of

  vsp_serial_rx u_rx (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .cs_n_pin       (cs_n_pin),
    .shift_clock_n  (shift_clock_n),
    .serial_data_in (serial_data_in),
    .out            (rx_if),
    .overrun        (overrun_pulse)
  );

  vsp_pair_buf #(.DEPTH(2)) u_buf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .in       (rx_if),
    .out      (dec_if)
  );

  // one idle cycle after each byte gives the ram write room to settle
  assign dec_if.ready = ~busy_reg;
  assign take         = dec_if.valid & dec_if.ready;
  assign first        = dec_if.data[FRAME_W-1];
  assign byte_in      = dec_if.data[7:0];
  assign sel          = byte_in[7:SEL_LSB];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy_reg <= 1'b0;
    else        busy_reg <= take;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) overrun <= 1'b0;
    else        overrun <= overrun_pulse;
  end

  // command decode; a byte flagged first always starts a new command
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= VSP_IDLE;
    end else if (take) begin
      if (first || state_reg == VSP_IDLE) begin
        case (sel)
          CMD_SYMBOL: state_reg <= VSP_SYM;
          CMD_DUTY:   state_reg <= VSP_DUTY;
          default:    state_reg <= VSP_IDLE;
        endcase
      end else begin
        case (state_reg)
          VSP_SYM:  state_reg <= VSP_SYM;
          VSP_DUTY: state_reg <= VSP_IDLE;
          default:  state_reg <= VSP_IDLE;
        endcase
      end
    end
  end

  // address increments in the data state so more bytes need no command
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sym_addr_reg <= '0;
    end else if (take) begin
      if ((first || state_reg == VSP_IDLE) && sel == CMD_SYMBOL) begin
        sym_addr_reg <= byte_in[SYM_AW-1:0];
      end else if (!first && state_reg == VSP_SYM) begin
        sym_addr_reg <= sym_addr_reg + SYM_AW'(1);
      end
    end
  end

  // addresses past the last digit are accepted but not stored
  always_ff @(posedge core_clk) begin
    if (take && !first && state_reg == VSP_SYM && sym_addr_reg < SYM_AW'(DIGITS)) begin
      sym_ram_reg[sym_addr_reg] <= byte_in[SYM_DW-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_level_bit <= PORT_RST;
    end else if (take && (first || state_reg == VSP_IDLE) && sel == CMD_PORT) begin
      port_level_bit <= byte_in[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_lo_reg <= 2'h0;
    end else if (take && (first || state_reg == VSP_IDLE) && sel == CMD_DUTY) begin
      duty_lo_reg <= byte_in[1:0];
    end
  end

  // value only changes once the second byte completes the pair
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_value <= DUTY_RST;
    end else if (take && !first && state_reg == VSP_DUTY) begin
      duty_value <= clamp_duty({byte_in, duty_lo_reg});
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      digit_count <= DIGIT_RST;
    end else if (take && (first || state_reg == VSP_IDLE) && sel == CMD_DIGITS) begin
      digit_count <= byte_in[3:0];
    end
  end

  // character code steering, registered for clean outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pattern_ram_sel  <= 1'b0;
      pattern_ram_addr <= 4'h0;
      rom_addr         <= 8'h00;
    end else begin
      pattern_ram_sel  <= (char_code_in <= PAT_TOP);
      pattern_ram_addr <= char_code_in[3:0];
      rom_addr         <= char_code_in;
    end
  end

  // scan: the host only changes digit count with display off, so
  // a mid-scan change is not guarded beyond restarting at grid 0
  assign last_grid = last_of(digit_count);
  assign lit       = display_on && (slot_reg < SLOT_W'(duty_value));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_reg <= '0;
      grid_reg <= '0;
    end else if (!display_on) begin
      slot_reg <= '0;
      grid_reg <= '0;
    end else begin
      slot_reg <= slot_reg + SLOT_W'(1);
      if (slot_reg == '1) begin
        grid_reg <= (grid_reg >= last_grid) ? '0 : grid_reg + SYM_AW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      grid_output <= '0;
      symbol_out  <= '0;
    end else begin
      grid_output <= '0;
      symbol_out  <= '0;
      if (lit && grid_reg <= last_grid && grid_reg < SYM_AW'(DIGITS)) begin
        grid_output[grid_reg] <= 1'b1;
        symbol_out            <= sym_ram_reg[grid_reg];
      end
    end
  end
endmodule : vsp_cmd_top
`default_nettype wire

// ===== logic/vsp_pair_buf.sv
// Purpose: two-entry buffer between byte receiver and decoder
// Assumes: both sides on core_clk
// Notes:   ready toward the receiver falls only when both entries hold
`timescale 1ns/1ps
`default_nettype none
module vsp_pair_buf #(
  parameter int unsigned DEPTH = 2
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  vsp_byte_if.snk   in,
  vsp_byte_if.src   out
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [in.W-1:0] mem_reg [DEPTH];
  logic [PW-1:0]   wr_reg;
  logic [PW-1:0]   rd_reg;
  logic [CW-1:0]   cnt_reg;
  logic            push;
  logic            pop;

  assign in.ready  = (cnt_reg != CW'(DEPTH));
  assign out.valid = (cnt_reg != '0);
  assign out.data  = mem_reg[rd_reg];
  assign push      = in.valid & in.ready;
  assign pop       = out.valid & out.ready;

  always_ff @(posedge core_clk) begin
    if (push) mem_reg[wr_reg] <= in.data;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
      if (pop)  rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end
endmodule : vsp_pair_buf
`default_nettype wire

// ===== logic/vsp_pkg.sv
// Purpose: shared constants and types of the display command block
// Assumes: byte frames arrive least significant bit first
// Notes:   one selector value per command, three bits wide
package vsp_pkg;
  localparam int unsigned SEL_LSB     = 5;
  localparam int unsigned FRAME_W     = 9;
  localparam logic [2:0]  CMD_PORT    = 3'h1;
  localparam logic [2:0]  CMD_DUTY    = 3'h5;
  localparam logic [2:0]  CMD_DIGITS  = 3'h3;
  localparam logic [2:0]  CMD_SYMBOL  = 3'h2;
  localparam int unsigned SYM_DIGITS  = 24;
  localparam int unsigned SYM_AW      = 5;
  localparam int unsigned SYM_DW      = 4;
  localparam int unsigned DUTY_W      = 10;
  localparam logic [9:0]  DUTY_MAX    = 10'h3c0;
  localparam logic [9:0]  DUTY_RST    = 10'h000;
  localparam logic [3:0]  PORT_RST    = 4'h0;
  localparam logic [3:0]  DIGIT_RST   = 4'h0;
  localparam logic [4:0]  DIGIT_OFS   = 5'h07;
  localparam logic [4:0]  FULL_LAST   = 5'h17;
  localparam logic [7:0]  PAT_TOP     = 8'h0f;
  localparam logic [2:0]  BYTE_LAST   = 3'h7;
  typedef enum logic [1:0] {
    VSP_IDLE = 2'b00,
    VSP_SYM  = 2'b01,
    VSP_DUTY = 2'b11
  } vsp_state_e;
endpackage : vsp_pkg

// ===== logic/vsp_serial_rx.sv
// Purpose: samples the serial link and assembles bytes
// Assumes: link pins are asynchronous to core_clk
// Notes:   a byte finding the buffer full is dropped and flagged
`timescale 1ns/1ps
`default_nettype none
module vsp_serial_rx
  import vsp_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic cs_n_pin,
  input  wire logic shift_clock_n,
  input  wire logic serial_data_in,
  vsp_byte_if.src   out,
  output logic      overrun
);
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic       clk_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       first_reg;
  logic       rise;

  // first stage is read only by the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 3'h7;
      s2_reg <= 3'h7;
    end else begin
      s1_reg <= {cs_n_pin, shift_clock_n, serial_data_in};
      s2_reg <= s1_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) clk_prev_reg <= 1'b1;
    else        clk_prev_reg <= s2_reg[1];
  end

  assign rise = s2_reg[1] & ~clk_prev_reg & ~s2_reg[2];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
      first_reg   <= 1'b1;
    end else if (s2_reg[2]) begin
      bit_cnt_reg <= 3'h0;
      first_reg   <= 1'b1;
    end else if (rise) begin
      shift_reg   <= {s2_reg[0], shift_reg[7:1]};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == BYTE_LAST) first_reg <= 1'b0;
    end
  end

  // load strobe made internally after the eighth bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out.valid <= 1'b0;
      out.data  <= '0;
      overrun   <= 1'b0;
    end else begin
      out.valid <= 1'b0;
      overrun   <= 1'b0;
      if (rise && bit_cnt_reg == BYTE_LAST) begin
        out.valid <= out.ready;
        overrun   <= ~out.ready;
        out.data  <= {first_reg, s2_reg[0], shift_reg[7:1]};
      end
    end
  end
endmodule : vsp_serial_rx
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench for the display command block
// Assumes: host model drives the link, bench drives the rest
// Notes:   slot width cut to 4 bits, so one grid slot is 16 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vsp_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic        display_on;
  logic [7:0]  char_code_in;
  wire logic   cs_n_pin, shift_clock_n, serial_data_in;
  logic [3:0]  port_level_bit, symbol_out, digit_count;
  logic [23:0] grid_output;
  logic        pattern_ram_sel;
  logic [7:0]  rom_addr;
  logic [3:0]  pattern_ram_addr;
  logic        overrun;
  logic [9:0]  duty_value;
  int          num_errors = 0;
  int          tests_run = 0;
  vsp_host_model host (.core_clk, .cs_n_pin, .shift_clock_n, .serial_data_in);
  vsp_cmd_top #(.DIGITS(24), .SLOT_W(4)) dut (
    .core_clk, .rst_n, .cs_n_pin, .shift_clock_n, .serial_data_in, .display_on,
    .char_code_in, .port_level_bit, .grid_output, .symbol_out, .pattern_ram_sel,
    .pattern_ram_addr, .rom_addr, .duty_value, .digit_count, .overrun);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic end_of_test;
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic wait_grid(input int g, input logic [3:0] sym, output int n);
    n = 0;
    while (grid_output[g] !== 1'b1) begin
      if (n == 600) begin
        num_errors++;
        $display("MISMATCH %0t grid %0d never lit", $time, g);
        end_of_test();
      end
      n++;
      @(negedge core_clk);
    end
    check_val({6'h00, symbol_out}, {6'h00, sym});
  endtask : wait_grid
  task automatic t_reset;
    rst_n = 1'b0;
    host.hold(2);
    check_val({6'h00, port_level_bit}, 10'h000);
    check_val(duty_value, 10'h000);
    check_val({6'h00, digit_count}, 10'h000);
    check_val(grid_output[9:0], 10'h000);
    rst_n = 1'b1;
    host.hold(4);
  endtask : t_reset
  task automatic t_port;
    host.send_frame('{8'h25});
    check_val({6'h00, port_level_bit}, 10'h005);
    host.send_frame('{8'h3a});
    check_val({6'h00, port_level_bit}, 10'h00a);
    host.send_frame('{8'h2f, 8'h31});
    check_val({6'h00, port_level_bit}, 10'h001);
    check_val({9'h000, overrun}, 10'h000);
  endtask : t_port
  task automatic t_duty;
    logic [9:0] v[4] = '{10'h3bf, 10'h3c1, 10'h3ff, 10'h008};
    foreach (v[i]) begin
      host.send_frame('{{6'h28, v[i][1:0]}, v[i][9:2]});
      check_val(duty_value, (v[i] > DUTY_MAX) ? DUTY_MAX : v[i]);
    end
  endtask : t_duty
  task automatic t_digits;
    for (int k = 15; k >= 0; k--) begin
      host.send_frame('{{4'h6, 4'(k)}});
      check_val({6'h00, digit_count}, 10'(k));
    end
  endtask : t_digits
  task automatic t_code;
    logic [7:0] c[4] = '{8'h00, 8'h0f, 8'h10, 8'hff};
    foreach (c[i]) begin
      char_code_in = c[i];
      host.hold(2);
      check_val({2'b00, rom_addr}, {2'b00, c[i]});
      check_val({9'h000, pattern_ram_sel}, {9'h000, c[i] <= PAT_TOP});
      check_val({6'h00, pattern_ram_addr}, {6'h00, c[i][3:0]});
    end
  endtask : t_code
  task automatic t_symbol;
    logic [7:0] q[$];
    int         n;
    q = '{8'h56, 8'hf5, 8'h0a};
    repeat (8) q.push_back(8'h03);
    q.push_back(8'h09);
    host.send_frame(q);
    display_on = 1'b1;
    wait_grid(22, 4'h5, n);
    wait_grid(23, 4'ha, n);
    check_val(10'(n), 10'h010);
    wait_grid(0, 4'h9, n);
    check_val(10'(n), 10'h010);
    display_on = 1'b0;
  endtask : t_symbol
  task automatic t_scan(input logic [3:0] cnt, input int period);
    int n;
    int m;
    host.hold(4);
    host.send_frame('{{4'h6, cnt}});
    display_on = 1'b1;
    wait_grid(0, 4'h9, n);
    m = 0;
    while (grid_output[0] === 1'b1 && m < 20) begin
      m++;
      @(negedge core_clk);
    end
    wait_grid(0, 4'h9, n);
    check_val(10'(m), 10'h008);
    check_val(10'(m + n), 10'(period));
    display_on = 1'b0;
  endtask : t_scan
  initial begin
    rst_n        = 1'b0;
    display_on   = 1'b0;
    char_code_in = 8'h00;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    host.hold(4);
    t_port();
    t_reset();
    t_duty();
    t_digits();
    t_code();
    t_symbol();
    t_scan(4'h1, 144);
    t_scan(4'hf, 368);
    t_scan(4'h0, 384);
    t_reset();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// ===== tb/vsp_cmd_checker.sv
// Purpose: port-level checks of the display command block
// Assumes: bound to vsp_cmd_top, single clock domain
// Notes:   register changes must trace back to a recent link frame
`timescale 1ns/1ps
`default_nettype none
module vsp_cmd_checker
  import vsp_pkg::*;
#(
  parameter int unsigned DIGITS = SYM_DIGITS,
  parameter int unsigned SLOT_W = DUTY_W
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              cs_n_pin,
  input wire logic              display_on,
  input wire logic [7:0]        char_code_in,
  input wire logic [3:0]        port_level_bit,
  input wire logic [DIGITS-1:0] grid_output,
  input wire logic [SYM_DW-1:0] symbol_out,
  input wire logic              pattern_ram_sel,
  input wire logic [3:0]        pattern_ram_addr,
  input wire logic [7:0]        rom_addr,
  input wire logic [DUTY_W-1:0] duty_value,
  input wire logic [3:0]        digit_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] idle_reg;
  logic [4:0] span;
  // saturating count of cycles since select was last low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) idle_reg <= 6'h3f;
    else if (!cs_n_pin) idle_reg <= 6'h00;
    else if (idle_reg != 6'h3f) idle_reg <= idle_reg + 6'h01;
  end
  assign span = (digit_count == 4'h0) ? 5'h18 : {1'b0, digit_count} + 5'h08;
  property p_reset_vals;
    $rose(rst_n) |-> port_level_bit == PORT_RST && duty_value == DUTY_RST
      && digit_count == DIGIT_RST && grid_output == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_cause;
    $changed(port_level_bit) || $changed(duty_value) || $changed(digit_count)
      |-> idle_reg < 6'h14;
  endproperty
  a_cause: assert property (p_cause) else $error("setting moved without a frame");
  property p_clamp;
    duty_value <= DUTY_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("duty above clamp");
  property p_onehot;
    $onehot0(grid_output);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two grids lit");
  property p_dark;
    !display_on [*3] |-> grid_output == '0;
  endproperty
  a_dark: assert property (p_dark) else $error("grid lit while display off");
  property p_beyond;
    (grid_output >> span) == '0;
  endproperty
  a_beyond: assert property (p_beyond) else $error("grid beyond count lit");
  property p_sym_dark;
    grid_output == '0 |-> symbol_out == '0;
  endproperty
  a_sym_dark: assert property (p_sym_dark) else $error("symbol without grid");
  property p_zero_duty;
    duty_value == DUTY_RST [*3] |-> grid_output == '0;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("grid lit at zero duty");
  property p_rom;
    1'b1 |=> rom_addr == $past(char_code_in);
  endproperty
  a_rom: assert property (p_rom) else $error("fixed pattern code wrong");
  property p_pat;
    1'b1 |=> pattern_ram_sel == (rom_addr <= PAT_TOP) && pattern_ram_addr == rom_addr[3:0];
  endproperty
  a_pat: assert property (p_pat) else $error("pattern ram steering wrong");
endmodule : vsp_cmd_checker
bind vsp_cmd_top vsp_cmd_checker #(.DIGITS(DIGITS), .SLOT_W(SLOT_W)) u_chk (
  .core_clk, .rst_n, .cs_n_pin, .display_on, .char_code_in, .port_level_bit,
  .grid_output, .symbol_out, .pattern_ram_sel, .pattern_ram_addr, .rom_addr,
  .duty_value, .digit_count);
`default_nettype wire

// ===== tb/vsp_host_model.sv
// Purpose: host side of the serial command link
// Assumes: called at a falling core_clk edge
// Notes:   shift clock idles high and stands still between frames
`timescale 1ns/1ps
`default_nettype none
module vsp_host_model (
  input  wire logic core_clk,
  output logic      cs_n_pin,
  output logic      shift_clock_n,
  output logic      serial_data_in
);
  initial begin
    cs_n_pin       = 1'b1;
    shift_clock_n  = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask : hold
  // four core cycles per half bit gives the 160 ns link period
  task automatic send_frame(input logic [7:0] q[$]);
    cs_n_pin = 1'b0;
    foreach (q[i]) begin
      for (int b = 0; b < 8; b++) begin
        shift_clock_n  = 1'b0;
        serial_data_in = q[i][b];
        hold(4);
        shift_clock_n = 1'b1;
        hold(4);
      end
    end
    cs_n_pin = 1'b1;
    // released line: no pull, so show the inverse of the last bit
    serial_data_in = ~serial_data_in;
    hold(12);
  endtask : send_frame
endmodule : vsp_host_model
`default_nettype wire
